// file: acq_pkg.sv
// shared constants of the acquisition control block
// assumes an 8-bit host i/o port synchronous to ref_clk
package acq_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [3:0] OFS_DATA_LO    = 4'h0;
  localparam logic [3:0] OFS_DATA_HI    = 4'h1;
  localparam logic [3:0] OFS_SCAN_RANGE = 4'h2;
  localparam logic [3:0] OFS_STATUS     = 4'h3;
  localparam logic [3:0] OFS_MODE       = 4'h4;
  localparam logic [3:0] OFS_THRESH     = 4'h5;
  localparam logic [3:0] OFS_DAC_LO     = 4'h6;
  localparam logic [3:0] OFS_DAC_HI     = 4'h7;
  // ==========================================================================
  // field positions
  localparam int MODE_IRQ_EN_BIT   = 0;
  localparam int MODE_TRIG_SEL_BIT = 4;
  localparam int ST_SCAN_EN_BIT    = 2;
  localparam int ST_DAC_BUSY_BIT   = 4;
  localparam int ST_OVF_BIT        = 5;
  localparam int ST_BUSY_BIT       = 7;
  localparam int FLUSH_BIT         = 0;
  // ==========================================================================
  // reset values and sizes
  localparam logic [7:0]  RST_SCAN_RANGE  = 8'h00;
  localparam logic [5:0]  RST_THRESH      = 6'h00;
  localparam logic [11:0] DAC_CODE_MID    = 12'h800;
  localparam int          FIFO_SAMPLES    = 48;
  localparam logic [5:0]  FIFO_SAMPLES_6  = 6'h30;
  localparam logic [1:0]  CLR_HOLD_CYC    = 2'h3;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int DAC_UPDATE_NS  = 30000;
  localparam int DAC_UPDATE_CYC = DAC_UPDATE_NS / CLK_PERIOD_NS;
  localparam int DAC_WORD_BITS  = 16;
  localparam int DAC_BIT_CYC    = DAC_UPDATE_CYC / DAC_WORD_BITS;
  // ==========================================================================
  // sequencer states
  typedef enum logic [1:0] {
    S_IDLE    = 2'b00,
    S_CONV    = 2'b01,
    S_PUSH_LO = 2'b10,
    S_PUSH_HI = 2'b11
  } acq_state_t;
endpackage : acq_pkg

// file: acq_byte_fifo.sv
// byte-wide sample store, one write and one pop port
// assumes the writer honours wr_ready and pops only when not empty
`timescale 1ns/1ps
`default_nettype none
module acq_byte_fifo
  import acq_pkg::*;
#(
  parameter int DEPTH = 2 * FIFO_SAMPLES,
  parameter int CW    = $clog2(DEPTH + 1)
)(
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // control
  input  wire logic          flush,
  // write side
  input  wire logic          wr_valid,
  input  wire logic [7:0]    wr_data,
  output logic               wr_ready,
  // read side
  input  wire logic          rd_pop,
  output logic [7:0]         rd_data,
  output logic [CW-1:0]      count
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================================
  // storage and pointers
  logic [7:0]    mem [DEPTH];       // byte storage
  logic [AW-1:0] wptr_q, wptr_d;    // write pointer
  logic [AW-1:0] rptr_q, rptr_d;    // read pointer
  logic [CW-1:0] cnt_q, cnt_d;      // bytes held
  logic          do_wr, do_rd;

  // pointer wrap helper
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  assign wr_ready = (cnt_q != CW'(DEPTH));
  assign rd_data  = mem[rptr_q];
  assign count    = cnt_q;
  assign do_wr    = wr_valid && wr_ready && !flush;
  assign do_rd    = rd_pop && (cnt_q != '0) && !flush;

  // next pointers; flush empties without touching storage
  always_comb
  begin
    wptr_d = do_wr ? bump(wptr_q) : wptr_q;
    rptr_d = do_rd ? bump(rptr_q) : rptr_q;
    cnt_d  = cnt_q + CW'(do_wr) - CW'(do_rd);
    if (flush)
    begin
      wptr_d = '0;
      rptr_d = '0;
      cnt_d  = '0;
    end
  end

  // pointer registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end
    else
    begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q  <= cnt_d;
    end
  end

  // storage write, no reset needed for data
  always_ff @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wptr_q] <= wr_data;
  end
endmodule : acq_byte_fifo
`default_nettype wire

// file: acq_dac_serial.sv
// serial shifter toward the four-channel d/a chip
// assumes the chip samples sdata on the rising sclk and latches on load_n low
`timescale 1ns/1ps
`default_nettype none
module acq_dac_serial
  import acq_pkg::*;
#(
  parameter int BIT_CYC = DAC_BIT_CYC,
  parameter int NBITS   = DAC_WORD_BITS
)(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // request
  input  wire logic             start,
  input  wire logic [NBITS-1:0] word,
  output logic                  busy,
  // chip pins
  output logic                  sclk,
  output logic                  sdata,
  output logic                  load_n
);
  // ==========================================================================
  // shift state
  logic [NBITS-1:0] sh_q, sh_d;     // bits still to send, msb first
  logic [15:0]      tick_q, tick_d; // cycles inside the current bit
  logic [5:0]       left_q, left_d; // bits left, zero means load phase
  logic             busy_q, busy_d;
  logic             load_q, load_d;
  logic             bit_end;

  assign bit_end = (tick_q == 16'(BIT_CYC - 1));

  // next state: shift one bit per bit period, then one load strobe
  always_comb
  begin
    sh_d   = sh_q;
    tick_d = tick_q;
    left_d = left_q;
    busy_d = busy_q;
    load_d = 1'b0;
    if (!busy_q)
    begin
      if (start)
      begin
        sh_d   = word;
        tick_d = '0;
        left_d = 6'(NBITS);
        busy_d = 1'b1;
      end
    end
    else if (left_q == '0)
    begin
      // load strobe cycle ends the update
      load_d = 1'b1;
      busy_d = 1'b0;
    end
    else
    begin
      tick_d = bit_end ? '0 : tick_q + 16'h0001;
      if (bit_end)
      begin
        sh_d   = {sh_q[NBITS-2:0], 1'b0};
        left_d = left_q - 6'h01;
      end
    end
  end

  // registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sh_q   <= '0;
      tick_q <= '0;
      left_q <= '0;
      busy_q <= 1'b0;
      load_q <= 1'b0;
    end
    else
    begin
      sh_q   <= sh_d;
      tick_q <= tick_d;
      left_q <= left_d;
      busy_q <= busy_d;
      load_q <= load_d;
    end
  end

  // clock high in the second half of each bit
  assign busy   = busy_q;
  assign sdata  = sh_q[NBITS-1];
  assign sclk   = busy_q && (left_q != '0) && (tick_q >= 16'(BIT_CYC / 2));
  assign load_n = !load_q;
endmodule : acq_dac_serial
`default_nettype wire

// file: acq_ctrl.sv
// acquisition control: a/d trigger modes, sample store, d/a write port
// assumes a host i/o port on ref_clk and a converter front end that
// answers conv_start with one conv_done pulse carrying a 16-bit result
`timescale 1ns/1ps
`default_nettype none
module acq_ctrl
  import acq_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // host i/o port
  input  wire logic [3:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  // trigger pins
  input  wire logic        trig_pin_timer,
  input  wire logic        trig_pin_ext,
  // converter front end
  output logic             conv_start,
  output logic [3:0]       conv_channel,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  // interrupt request
  output logic             adc_irq,
  // d/a chip
  output logic             dac_sclk,
  output logic             dac_sdata,
  output logic             dac_load_n,
  input  wire logic        dac_bipolar_strap,
  output logic             dac_clear,
  output logic             dac_clear_midscale
);
  // ==========================================================================
  // pin synchronisers
  logic [2:0] s1_q, s2_q, s3_q;     // three-stage chains
  logic [2:0] lvl_q, lvl_d;         // agreed levels
  logic [1:0] lvl_prev_q;           // for trigger edges
  logic [2:0] pins;

  assign pins = {dac_bipolar_strap, trig_pin_ext, trig_pin_timer};

  // a change counts once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
  end

  // chain registers, kept out of reset on purpose: the strap level has
  // settled by release, and a pin held high gives no false edge after it
  always_ff @(posedge ref_clk)
  begin
    s1_q       <= pins;
    s2_q       <= s1_q;
    s3_q       <= s2_q;
    lvl_q      <= lvl_d;
    lvl_prev_q <= lvl_q[1:0];
  end

  // ==========================================================================
  // control registers
  logic [3:0]  first_ch_q, first_ch_d;     // scan range start
  logic [3:0]  last_ch_q, last_ch_d;       // scan range end
  logic        scan_en_q, scan_en_d;       // channel_range_scan_enable
  logic        irq_en_q, irq_en_d;         // adc_irq_enable
  logic        trig_sel_q, trig_sel_d;     // adc_trigger_select
  logic [5:0]  thresh_q, thresh_d;         // interrupt level in samples
  logic [7:0]  dac_low_q, dac_low_d;       // pending low code byte
  logic        wr_any;
  logic        dac_busy;
  logic        dac_accept;
  logic        flush;

  assign wr_any     = io_wr;
  assign dac_accept = wr_any && (io_addr == OFS_DAC_HI) && !dac_busy;
  assign flush      = wr_any && (io_addr == OFS_DATA_HI) && io_wdata[FLUSH_BIT];

  // host writes into the control fields
  always_comb
  begin
    first_ch_d = first_ch_q;
    last_ch_d  = last_ch_q;
    scan_en_d  = scan_en_q;
    irq_en_d   = irq_en_q;
    trig_sel_d = trig_sel_q;
    thresh_d   = thresh_q;
    dac_low_d  = dac_low_q;
    if (wr_any)
    begin
      case (io_addr)
        OFS_SCAN_RANGE:
        begin
          first_ch_d = io_wdata[3:0];
          last_ch_d  = io_wdata[7:4];
        end
        OFS_STATUS: scan_en_d = io_wdata[ST_SCAN_EN_BIT];
        OFS_MODE:
        begin
          irq_en_d   = io_wdata[MODE_IRQ_EN_BIT];
          trig_sel_d = io_wdata[MODE_TRIG_SEL_BIT];
        end
        OFS_THRESH: thresh_d = io_wdata[5:0];
        // low byte is ignored while an update shifts out
        OFS_DAC_LO: dac_low_d = dac_busy ? dac_low_q : io_wdata;
        default: ;
      endcase
    end
  end

  // control registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      first_ch_q <= RST_SCAN_RANGE[3:0];
      last_ch_q  <= RST_SCAN_RANGE[7:4];
      scan_en_q  <= 1'b0;
      irq_en_q   <= 1'b0;
      trig_sel_q <= 1'b0;
      thresh_q   <= RST_THRESH;
      dac_low_q  <= '0;
    end
    else
    begin
      first_ch_q <= first_ch_d;
      last_ch_q  <= last_ch_d;
      scan_en_q  <= scan_en_d;
      irq_en_q   <= irq_en_d;
      trig_sel_q <= trig_sel_d;
      thresh_q   <= thresh_d;
      dac_low_q  <= dac_low_d;
    end
  end

  // ==========================================================================
  // trigger choice
  logic trig_rise_timer, trig_rise_ext, trig;

  assign trig_rise_timer = lvl_q[0] && !lvl_prev_q[0];
  assign trig_rise_ext   = lvl_q[1] && !lvl_prev_q[1];
  // select 0 takes the timer tick, 1 the external pin
  assign trig = irq_en_q ? (trig_sel_q ? trig_rise_ext : trig_rise_timer)
                         : (wr_any && io_addr == OFS_DATA_LO);

  // ==========================================================================
  // conversion sequencer
  acq_state_t  st_q, st_d;
  logic [3:0]  ch_q, ch_d;          // channel being or next converted
  logic [15:0] res_q, res_d;        // result awaiting the store
  logic        start_q, start_d;    // one-cycle start toward converter
  logic        ovf_q, ovf_d;        // fifo_overflow_flag
  logic        fifo_wr_valid, fifo_wr_ready;
  logic [7:0]  fifo_wr_data, fifo_rd_data;
  logic [6:0]  fifo_count;
  logic [5:0]  samples;
  logic        fifo_pop;
  logic        scan_more;

  assign samples   = fifo_count[6:1];
  assign scan_more = scan_en_q && (ch_q != last_ch_q);

  // next channel with wrap back to the first of the range
  function automatic logic [3:0] next_ch(input logic [3:0] c, input logic [3:0] lo,
                                         input logic [3:0] hi);
    next_ch = (c == hi) ? lo : c + 4'h1;
  endfunction : next_ch

  // store bytes: low half first, then high half
  always_comb
  begin
    fifo_wr_valid = (st_q == S_PUSH_LO) || (st_q == S_PUSH_HI);
    fifo_wr_data  = (st_q == S_PUSH_HI) ? res_q[15:8] : res_q[7:0];
  end

  // sequencer next state
  always_comb
  begin
    st_d    = st_q;
    ch_d    = ch_q;
    res_d   = res_q;
    start_d = 1'b0;
    ovf_d   = flush ? 1'b0 : ovf_q;
    // a new range restarts the channel walk
    if (wr_any && io_addr == OFS_SCAN_RANGE)
      ch_d = io_wdata[3:0];
    case (st_q)
      S_IDLE:
      begin
        // triggers while busy are dropped
        if (trig)
        begin
          st_d    = S_CONV;
          start_d = 1'b1;
          if (scan_en_q)
            ch_d = first_ch_q;
        end
      end
      S_CONV:
      begin
        if (conv_done)
        begin
          res_d = conv_data;
          // full store or held overflow: keep contents, drop result
          if (ovf_q || samples >= FIFO_SAMPLES_6)
          begin
            ovf_d = 1'b1;
            if (scan_more)
            begin
              ch_d    = ch_q + 4'h1;
              start_d = 1'b1;
            end
            else
            begin
              st_d = S_IDLE;
              if (!scan_en_q)
                ch_d = next_ch(ch_q, first_ch_q, last_ch_q);
            end
          end
          else
            st_d = S_PUSH_LO;
        end
      end
      S_PUSH_LO:
      begin
        if (fifo_wr_ready)
          st_d = S_PUSH_HI;
      end
      S_PUSH_HI:
      begin
        if (fifo_wr_ready)
        begin
          if (scan_more)
          begin
            // next channel of the scan, busy stays up
            ch_d    = ch_q + 4'h1;
            start_d = 1'b1;
            st_d    = S_CONV;
          end
          else
          begin
            // last conversion done, single mode steps for the next trigger
            st_d = S_IDLE;
            if (!scan_en_q)
              ch_d = next_ch(ch_q, first_ch_q, last_ch_q);
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q    <= S_IDLE;
      ch_q    <= RST_SCAN_RANGE[3:0];
      res_q   <= '0;
      start_q <= 1'b0;
      ovf_q   <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      ch_q    <= ch_d;
      res_q   <= res_d;
      start_q <= start_d;
      ovf_q   <= ovf_d;
    end
  end

  assign conv_start   = start_q;
  assign conv_channel = ch_q;

  acq_byte_fifo #(
    .DEPTH (2 * FIFO_SAMPLES),
    .CW    (7)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .flush    (flush),
    .wr_valid (fifo_wr_valid),
    .wr_data  (fifo_wr_data),
    .wr_ready (fifo_wr_ready),
    .rd_pop   (fifo_pop),
    .rd_data  (fifo_rd_data),
    .count    (fifo_count)
  );

  // ==========================================================================
  // interrupt level; zero threshold never fires
  logic irq_q, irq_d;

  always_comb
  begin
    irq_d = irq_en_q && (thresh_q != '0) && (samples >= thresh_q);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign adc_irq = irq_q;

  // ==========================================================================
  // host reads; data bytes pop the store
  logic [7:0] rdata_q, rdata_d;
  logic       conv_busy;

  assign conv_busy = (st_q != S_IDLE);
  assign fifo_pop  = io_rd && (io_addr == OFS_DATA_LO || io_addr == OFS_DATA_HI);

  always_comb
  begin
    rdata_d = rdata_q;
    if (io_rd)
    begin
      case (io_addr)
        OFS_DATA_LO,
        OFS_DATA_HI:    rdata_d = fifo_rd_data;
        OFS_SCAN_RANGE: rdata_d = {last_ch_q, first_ch_q};
        OFS_STATUS:     rdata_d = {conv_busy, 1'b0, ovf_q, dac_busy,
                                   1'b0, scan_en_q, 2'b00};
        OFS_MODE:       rdata_d = {3'b000, trig_sel_q, 3'b000, irq_en_q};
        OFS_THRESH:     rdata_d = {2'b00, thresh_q};
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign io_rdata = rdata_q;

  // ==========================================================================
  // d/a write port: channel in 7:6, code nibble in 3:0, 5:4 dropped
  logic [15:0] dac_word;

  assign dac_word = {2'b00, io_wdata[7:6], io_wdata[3:0], dac_low_q};

  // codes pass untouched; bipolar offset binary is the chip's wiring
  acq_dac_serial #(
    .BIT_CYC (DAC_BIT_CYC),
    .NBITS   (DAC_WORD_BITS)
  ) u_dac (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (dac_accept),
    .word    (dac_word),
    .busy    (dac_busy),
    .sclk    (dac_sclk),
    .sdata   (dac_sdata),
    .load_n  (dac_load_n)
  );

  // ==========================================================================
  // power-up clear; strap caught once the synchroniser has settled
  logic [1:0] clr_cnt_q, clr_cnt_d;
  logic       mid_q, mid_d;

  always_comb
  begin
    clr_cnt_d = (clr_cnt_q == CLR_HOLD_CYC) ? clr_cnt_q : clr_cnt_q + 2'h1;
    mid_d     = (clr_cnt_q == CLR_HOLD_CYC - 2'h1) ? lvl_q[2] : mid_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      clr_cnt_q <= '0;
      mid_q     <= 1'b0;
    end
    else
    begin
      clr_cnt_q <= clr_cnt_d;
      mid_q     <= mid_d;
    end
  end

  // clear is zero scale in both modes; midscale takes the strap level in the cycle clear drops and holds it after
  assign dac_clear          = (clr_cnt_q != CLR_HOLD_CYC);
  assign dac_clear_midscale = mid_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_push_lo;
    st_q == S_PUSH_LO && fifo_wr_ready;
  endsequence
  sequence s_push_hi_last;
    st_q == S_PUSH_HI && fifo_wr_ready && !scan_more;
  endsequence
  sequence s_push_hi_more;
    st_q == S_PUSH_HI && fifo_wr_ready && scan_more;
  endsequence

  AST_IRQ_OFF: assert property (!irq_en_q |=> !adc_irq)
    else $error("interrupt raised with interrupt mode off");
  AST_IRQ_LEVEL: assert property (irq_en_q && thresh_q != '0 && samples >= thresh_q |=> adc_irq)
    else $error("interrupt missing at threshold");
  AST_SW_TRIG: assert property (st_q == S_IDLE && !irq_en_q && io_wr && io_addr == OFS_DATA_LO
                                |=> conv_start && conv_busy)
    else $error("software trigger did not start conversion");
  AST_BUSY_CONV: assert property (conv_start |-> conv_busy)
    else $error("busy low during conversion");
  AST_SCAN_HOLD: assert property (s_push_hi_more |=> conv_busy && conv_start
                                  && conv_channel == $past(ch_q) + 4'h1)
    else $error("scan did not continue on next channel");
  AST_BUSY_DROP: assert property (s_push_hi_last |=> !conv_busy)
    else $error("busy held after last conversion");
  AST_PUSH_ORDER: assert property (s_push_lo |-> fifo_wr_data == res_q[7:0] ##1
                                   fifo_wr_data == res_q[15:8])
    else $error("result bytes stored out of order");
  AST_OVF: assert property (st_q == S_CONV && conv_done && samples >= FIFO_SAMPLES_6
                            |=> ovf_q && st_q != S_PUSH_LO)
    else $error("overflow not flagged or data accepted");
  AST_DAC_START: assert property (dac_accept |=> dac_busy [*8])
    else $error("d/a update busy not held");
endmodule : acq_ctrl
`default_nettype wire

// file: acq_fe_model.sv
// converter front end model: answers each start with one done pulse
// assumes conv_start is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`default_nettype none
module acq_fe_model #(
  parameter int DLY = 5
)(
  // clock
  input  wire logic       ref_clk,
  // converter side
  input  wire logic       conv_start,
  input  wire logic [3:0] conv_channel,
  output var logic        conv_done = 1'b0,
  output var logic [15:0] conv_data = 16'h0000
);
  int cnt = 0; // cycles left in the conversion
  // ==========================================================================
  // result carries the channel in its top nibble; data scrambles when not valid
  always_ff @(posedge ref_clk)
  begin
    conv_done <= (cnt == 1);
    conv_data <= (cnt == 1) ? {conv_channel, 12'h123} : ~conv_data;
    cnt       <= conv_start ? DLY : ((cnt > 0) ? cnt - 1 : 0);
  end
endmodule : acq_fe_model
`default_nettype wire

// file: adc_mode_and_dac_write_port_tb_top.sv
// self-checking bench for the acquisition control block
// assumes the front end model answers every conversion start
`timescale 1ns/1ps
`default_nettype none
module adc_mode_and_dac_write_port_tb_top;
  logic ref_clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, trig_ext = 1'b0, strap = 1'b1;
  logic [3:0] io_addr = 4'h0, conv_channel;
  logic [7:0] io_wdata = 8'h00, io_rdata, s;
  logic conv_start, conv_done, adc_irq, dac_sclk, dac_sdata, dac_load_n, dac_clear, dac_mid;
  logic [15:0] conv_data;
  logic [15:0] sh = 16'h0000; // serial word seen on the d/a pins
  int failures = 0, n_checks = 0, n_starts = 0, n_loads = 0;
  // register rows: offset, write value, expected read back
  logic [3:0] ra [6] = '{4'h2, 4'h5, 4'h4, 4'h3, 4'h6, 4'h9};
  logic [7:0] rw [6] = '{8'ha5, 8'hff, 8'h11, 8'h04, 8'h12, 8'h55};
  logic [7:0] re [6] = '{8'ha5, 8'h3f, 8'h11, 8'h04, 8'h00, 8'h00};
  // ==========================================================================
  // clock, monitors, watchdog
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (conv_start === 1'b1) n_starts++;
  always @(posedge ref_clk) if (dac_load_n === 1'b0) n_loads++;
  always @(posedge dac_sclk) sh = {sh[14:0], dac_sdata};
  initial
  begin
    #300000;
    failures++;
    final_report();
  end
  acq_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .trig_pin_timer(1'b0), .trig_pin_ext(trig_ext),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_data(conv_data), .adc_irq(adc_irq), .dac_sclk(dac_sclk), .dac_sdata(dac_sdata),
    .dac_load_n(dac_load_n), .dac_bipolar_strap(strap), .dac_clear(dac_clear),
    .dac_clear_midscale(dac_mid));
  acq_fe_model i_fe (.ref_clk(ref_clk), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_done(conv_done), .conv_data(conv_data));
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    @(negedge ref_clk);
    d = io_rdata;
  endtask : rd
  // poll a status bit until it drops, bounded
  task automatic wait_low(input int b);
    logic [7:0] v;
    logic       low;
    low = 1'b0;
    for (int i = 0; i < 3000 && !low; i++)
    begin
      rd(4'h3, v);
      low = (v[b] === 1'b0);
    end
    if (!low)
    begin
      failures++;
      final_report();
    end
  endtask : wait_low
  task automatic final_report;
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (20) @(negedge ref_clk);
    chk(dac_clear, 1'b1);
    chk(dac_load_n, 1'b1);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(dac_mid, 1'b1);
    chk(dac_clear, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      wr(ra[i], rw[i]);
      rd(ra[i], s);
      chk(s, re[i]);
    end
    // software single conversion, channels 3..5, threshold 1
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h5, 8'h01);
    wr(4'h2, 8'h53);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h00);
    chk(conv_channel, 4'h3);
    rd(4'h3, s);
    chk(s[7], 1'b1);
    wait_low(7);
    chk(adc_irq, 1'b0);
    rd(4'h0, s);
    chk(s, 8'h23);
    rd(4'h1, s);
    chk(s, 8'h31);
    // software scan of three channels, busy held across all
    n_starts = 0;
    wr(4'h3, 8'h04);
    wr(4'h0, 8'h00);
    wait_low(7);
    chk(16'(n_starts), 16'h0003);
    // interrupt mode: host write ignored, external pin scans 0..1
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h10);
    wr(4'h5, 8'h02);
    wr(4'h4, 8'h11);
    n_starts = 0;
    wr(4'h0, 8'h00);
    repeat (10) @(negedge ref_clk);
    chk(16'(n_starts), 16'h0000);
    trig_ext = 1'b1;
    repeat (6) @(negedge ref_clk);
    trig_ext = 1'b0;
    wait_low(7);
    repeat (2) @(negedge ref_clk);
    chk(16'(n_starts), 16'h0002);
    chk(adc_irq, 1'b1);
    // handler reads exactly the threshold, two samples; the level drops once the first byte is popped
    rd(4'h0, s);
    chk(s, 8'h23);
    rd(4'h1, s);
    chk(s, 8'h01);
    rd(4'h0, s);
    rd(4'h1, s);
    chk(s, 8'h11);
    chk(adc_irq, 1'b0);
    // d/a write, channel 3 code 0x6f0, unused bits set
    wr(4'h4, 8'h00);
    wr(4'h6, 8'hf0);
    wr(4'h7, 8'hf6);
    rd(4'h3, s);
    chk(s[4], 1'b1);
    wait_low(4);
    chk(sh, 16'h36f0);
    chk(16'(n_loads), 16'h0001);
    // overflow: three scans of 16 fill 48 samples, the fourth is dropped
    wr(4'h1, 8'h01);
    wr(4'h2, 8'hf0);
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h0, 8'h00);
      wait_low(7);
    end
    rd(4'h3, s);
    chk(s[5], 1'b1);
    rd(4'h0, s);
    chk(s, 8'h23);
    wr(4'h1, 8'h01);
    rd(4'h3, s);
    chk(s[5], 1'b0);
    // second reset with the strap low: outputs clear to zero scale
    strap = 1'b0;
    rst   = 1'b1;
    repeat (20) @(negedge ref_clk);
    chk(dac_clear, 1'b1);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(dac_mid, 1'b0);
    chk(dac_clear, 1'b0);
    rd(4'h3, s);
    chk(s, 8'h00);
    final_report();
  end
endmodule : adc_mode_and_dac_write_port_tb_top
`default_nettype wire
